// >>> logic/twelve_bit_instr_decode_exec.sv
// decode and execute slice of a twelve-bit accumulator processor
`default_nettype none
// Contract
// - increment-skip adds one, writes back, keeps accumulator
// - incremented word zero skips next instruction
// - deposit writes accumulator, then clears it
// - subroutine call stores return, jumps past it
// - jump loads effective address into counter
// - memory instructions: 3.2 direct, 4.8 indirect
// - jump: 1.6 direct, 3.2 indirect
// - opcodes 6, 7 execute in fetch only
// - i/o transfer sets pause, stretches fetch
// - three gated pulses one microsecond apart
// - bit 8 selects operate group
// - empty operate spends one plain cycle
// - step 1 clears link and/or accumulator
// - step 2 inverts accumulator and/or link
// - step 3 increments the accumulator
// - invert then increment gives negation
// - step 4 rotates link-accumulator left once
// - step 4 rotates link-accumulator right once
// - two-bit rotates equal two single rotates
// - bit 3 chooses any-true or none-true skip
// - bits 6,5,4 choose minus, zero, link tests
// - page bit and indirect bit form address
module twelve_bit_instr_decode_exec (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire twelve_bit_pkg::wbReq_t wbReq,
	output logic wbAck,
	output logic [31:0] wbDatOut,
	output twelve_bit_pkg::memReq_t memReq,
	input wire logic [11:0] memRdData,
	output logic [2:0] ioPulse,
	output logic [5:0] ioDevice,
	output logic pauseFlag
);

	// ****************************************
	// functions
	// ****************************************

	// one rotate step of the 13-bit link-plus-accumulator
	function automatic logic [12:0] rotateOne(input logic [12:0] v, input logic left);
		if (left)
			rotateOne = {v[11:0], v[12]};
		else
			rotateOne = {v[0], v[12:1]};
	endfunction

	// byte-lane merge for 13-bit software registers
	function automatic logic [12:0] mergeLanes(input logic [12:0] old,
		input logic [31:0] dat, input logic [3:0] sel);
		mergeLanes = old;
		if (sel[0])
			mergeLanes[7:0] = dat[7:0];
		if (sel[1])
			mergeLanes[12:8] = dat[12:8];
	endfunction

	// ****************************************
	// state
	// ****************************************
	twelve_bit_pkg::majorState_t stateQ; // major state
	logic [5:0] tickQ; // clock count within the current cycle
	logic [11:0] instrRegQ; // instruction register
	logic [11:0] memBufQ; // memory buffer
	logic [11:0] progCounterQ; // program counter
	logic [11:0] accQ; // accumulator
	logic linkQ; // link bit
	logic [11:0] effAddrQ; // effective address
	logic pauseQ; // stretched-fetch flag
	logic runQ; // software run request
	logic ackQ; // bus acknowledge
	logic [31:0] datOutQ; // bus read data
	twelve_bit_pkg::memReq_t memReqQ; // memory request
	logic [2:0] ioPulseQ; // timing pulses

	// ****************************************
	// decode
	// ****************************************
	logic [2:0] opcode;
	logic isMemRef; // one of the four memory instructions kept here
	logic lastTick; // final tick of the current cycle
	logic accZero;
	logic anyCond;
	logic skipNow; // group 2 skip decision
	logic rotLeft;
	logic rotRight;
	logic [12:0] rotOnce;
	logic [12:0] rotated;
	logic busHit;
	logic busWrite;
	logic halted;

	assign opcode = instrRegQ[11:9];
	assign isMemRef = (opcode >= twelve_bit_pkg::OP_INCR_SKIP_ZERO)
		&& (opcode <= twelve_bit_pkg::OP_JUMP_DIRECT);
	// stretched fetch only while the pause flag is up
	assign lastTick = (stateQ == twelve_bit_pkg::ST_FETCH && pauseQ)
		? (tickQ == twelve_bit_pkg::TICK_IOT_END)
		: (tickQ == twelve_bit_pkg::TICK_MEM_END);
	assign accZero = (accQ == 12'h000);
	// inclusive or of the selected tests
	assign anyCond = (instrRegQ[twelve_bit_pkg::B_TEST_MINUS] & accQ[11])
		| (instrRegQ[twelve_bit_pkg::B_TEST_ACC_ZERO] & accZero)
		| (instrRegQ[twelve_bit_pkg::B_TEST_LINK_SET] & linkQ);
	// reverse sense: skip only when no selected test holds
	assign skipNow = instrRegQ[twelve_bit_pkg::B_REVERSE] ? !anyCond : anyCond;
	assign rotLeft = instrRegQ[twelve_bit_pkg::B_ROT_LEFT];
	assign rotRight = instrRegQ[twelve_bit_pkg::B_ROT_RIGHT];
	assign rotOnce = rotateOne({linkQ, accQ}, rotLeft);
	// a double rotate is just the single step applied twice
	assign rotated = instrRegQ[twelve_bit_pkg::B_ROT_TWO]
		? rotateOne(rotOnce, rotLeft) : rotOnce;
	assign busHit = wbReq.cyc && wbReq.stb && !ackQ;
	assign busWrite = busHit && wbReq.we;
	assign halted = (stateQ == twelve_bit_pkg::ST_IDLE);

	// ****************************************
	// cycle timing
	// ****************************************

	// tick counter, restarts at every major-state boundary
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			tickQ <= 6'h00;
		else if (halted || lastTick)
			tickQ <= 6'h00;
		else
			tickQ <= tickQ + 6'h01;
	end

	// major state sequencing, decided at the end of each cycle
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			stateQ <= twelve_bit_pkg::ST_IDLE;
		else if (halted)
		begin
			if (runQ)
				stateQ <= twelve_bit_pkg::ST_FETCH;
		end
		else if (lastTick)
		begin
			case (stateQ)
				twelve_bit_pkg::ST_FETCH:
				begin
					// operate and i/o never leave fetch
					if (isMemRef && instrRegQ[twelve_bit_pkg::B_INDIRECT])
						stateQ <= twelve_bit_pkg::ST_DEFER;
					else if (isMemRef && opcode != twelve_bit_pkg::OP_JUMP_DIRECT)
						stateQ <= twelve_bit_pkg::ST_EXEC;
					else if (!runQ)
						stateQ <= twelve_bit_pkg::ST_IDLE;
					else
						stateQ <= twelve_bit_pkg::ST_FETCH;
				end
				twelve_bit_pkg::ST_DEFER:
				begin
					// the indirect jump is done after its one extra cycle
					if (opcode != twelve_bit_pkg::OP_JUMP_DIRECT)
						stateQ <= twelve_bit_pkg::ST_EXEC;
					else if (!runQ)
						stateQ <= twelve_bit_pkg::ST_IDLE;
					else
						stateQ <= twelve_bit_pkg::ST_FETCH;
				end
				twelve_bit_pkg::ST_EXEC:
					stateQ <= runQ ? twelve_bit_pkg::ST_FETCH : twelve_bit_pkg::ST_IDLE;
				default:
					stateQ <= twelve_bit_pkg::ST_IDLE;
			endcase
		end
	end

	// ****************************************
	// memory port
	// ****************************************

	// read at tick 0 of every cycle, write-back in the execute cycle
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			memReqQ <= '0;
		else
		begin
			memReqQ.rd <= 1'b0;
			memReqQ.wr <= 1'b0;
			if (!halted && tickQ == 6'h00)
			begin
				memReqQ.rd <= 1'b1;
				// fetch reads at the counter, the others at the address
				memReqQ.addr <= (stateQ == twelve_bit_pkg::ST_FETCH)
					? progCounterQ : effAddrQ;
			end
			else if (stateQ == twelve_bit_pkg::ST_EXEC
				&& tickQ == twelve_bit_pkg::TICK_WRITE)
			begin
				// the three execute-cycle instructions all store a word
				memReqQ.wr <= 1'b1;
				memReqQ.wrData <= memBufQ;
			end
		end
	end

	// ****************************************
	// instruction, buffer and address
	// ****************************************

	// instruction register, loaded only in fetch
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			instrRegQ <= 12'h000;
		else if (stateQ == twelve_bit_pkg::ST_FETCH && tickQ == twelve_bit_pkg::TICK_LOAD)
			instrRegQ <= memRdData;
	end

	// memory buffer: read data, then the word to write back
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			memBufQ <= 12'h000;
		else if (!halted && tickQ == twelve_bit_pkg::TICK_LOAD)
			memBufQ <= memRdData;
		else if (stateQ == twelve_bit_pkg::ST_EXEC && tickQ == twelve_bit_pkg::TICK_SEQ1)
		begin
			case (opcode)
				twelve_bit_pkg::OP_INCR_SKIP_ZERO:
					memBufQ <= memBufQ + 12'h001;
				twelve_bit_pkg::OP_DEPOSIT_CLEAR_ACC:
					memBufQ <= accQ;
				twelve_bit_pkg::OP_JUMP_SUBROUTINE:
					memBufQ <= progCounterQ;
				default:
					memBufQ <= memBufQ;
			endcase
		end
	end

	// effective address: page plus offset, then pointer on defer
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			effAddrQ <= 12'h000;
		else if (stateQ == twelve_bit_pkg::ST_FETCH && tickQ == twelve_bit_pkg::TICK_SEQ1)
		begin
			// page comes from where the instruction itself was read
			if (instrRegQ[twelve_bit_pkg::B_CUR_PAGE])
				effAddrQ <= {memReqQ.addr[11:7], instrRegQ[6:0]};
			else
				effAddrQ <= {5'h00, instrRegQ[6:0]};
		end
		else if (stateQ == twelve_bit_pkg::ST_DEFER && tickQ == twelve_bit_pkg::TICK_LOAD)
			effAddrQ <= memRdData;
	end

	// ****************************************
	// program counter
	// ****************************************

	// software may load it only while halted
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			progCounterQ <= twelve_bit_pkg::RST_PROG_COUNTER;
		else if (halted)
		begin
			if (busWrite && wbReq.adr == twelve_bit_pkg::REG_PROG_COUNTER)
				progCounterQ <= 12'(mergeLanes({1'b0, progCounterQ}, wbReq.dat, wbReq.sel));
		end
		else if (stateQ == twelve_bit_pkg::ST_FETCH && tickQ == twelve_bit_pkg::TICK_SEQ1)
		begin
			// step past the instruction, and past the next on a skip
			if (opcode == twelve_bit_pkg::OP_OPERATE
				&& instrRegQ[twelve_bit_pkg::B_GROUP] && skipNow)
				progCounterQ <= progCounterQ + 12'h002;
			else
				progCounterQ <= progCounterQ + 12'h001;
		end
		else if (lastTick && stateQ != twelve_bit_pkg::ST_EXEC
			&& opcode == twelve_bit_pkg::OP_JUMP_DIRECT
			&& (stateQ == twelve_bit_pkg::ST_DEFER || !instrRegQ[twelve_bit_pkg::B_INDIRECT]))
			progCounterQ <= effAddrQ;
		else if (stateQ == twelve_bit_pkg::ST_EXEC && tickQ == twelve_bit_pkg::TICK_SEQ1
			&& opcode == twelve_bit_pkg::OP_JUMP_SUBROUTINE)
			progCounterQ <= effAddrQ + 12'h001;
		else if (stateQ == twelve_bit_pkg::ST_EXEC && tickQ == twelve_bit_pkg::TICK_WRITE
			&& opcode == twelve_bit_pkg::OP_INCR_SKIP_ZERO && memBufQ == 12'h000)
			progCounterQ <= progCounterQ + 12'h001;
	end

	// ****************************************
	// accumulator and link
	// ****************************************

	// group 1 steps run one per tick in fixed order
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			accQ <= twelve_bit_pkg::RST_ACC;
			linkQ <= 1'b0;
		end
		else if (halted)
		begin
			if (busWrite && wbReq.adr == twelve_bit_pkg::REG_ACC)
				{linkQ, accQ} <= mergeLanes({linkQ, accQ}, wbReq.dat, wbReq.sel);
		end
		else if (stateQ == twelve_bit_pkg::ST_EXEC)
		begin
			// buffer took the old value on this same edge
			if (tickQ == twelve_bit_pkg::TICK_SEQ1
				&& opcode == twelve_bit_pkg::OP_DEPOSIT_CLEAR_ACC)
				accQ <= 12'h000;
		end
		else if (stateQ == twelve_bit_pkg::ST_FETCH && opcode == twelve_bit_pkg::OP_OPERATE
			&& !instrRegQ[twelve_bit_pkg::B_GROUP])
		begin
			// an all-zero group 1 word falls through every step
			case (tickQ)
				twelve_bit_pkg::TICK_SEQ1:
				begin
					if (instrRegQ[twelve_bit_pkg::B_ZERO_ACC])
						accQ <= 12'h000;
					if (instrRegQ[twelve_bit_pkg::B_ZERO_LINK])
						linkQ <= 1'b0;
				end
				twelve_bit_pkg::TICK_SEQ2:
				begin
					if (instrRegQ[twelve_bit_pkg::B_INVERT_ACC])
						accQ <= ~accQ;
					if (instrRegQ[twelve_bit_pkg::B_INVERT_LINK])
						linkQ <= ~linkQ;
				end
				twelve_bit_pkg::TICK_SEQ3:
				begin
					if (instrRegQ[twelve_bit_pkg::B_INCR_ACC])
						accQ <= accQ + 12'h001;
				end
				twelve_bit_pkg::TICK_SEQ4:
				begin
					// both directions at once is a program error; leave data alone
					if (rotLeft != rotRight)
						{linkQ, accQ} <= rotated;
				end
				default:
					accQ <= accQ;
			endcase
		end
	end

	// ****************************************
	// i/o transfer timing
	// ****************************************

	// pause flag stretches the fetch and drops with the cycle
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			pauseQ <= 1'b0;
		else if (lastTick)
			pauseQ <= 1'b0;
		else if (stateQ == twelve_bit_pkg::ST_FETCH && tickQ == twelve_bit_pkg::TICK_SEQ1
			&& opcode == twelve_bit_pkg::OP_IO_TRANSFER)
			pauseQ <= 1'b1;
	end

	// one-cycle pulses at the three event times, gated by bits 0..2
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			ioPulseQ <= 3'h0;
		else if (stateQ == twelve_bit_pkg::ST_FETCH && pauseQ)
		begin
			ioPulseQ[0] <= (tickQ == twelve_bit_pkg::TICK_EV1) && instrRegQ[0];
			ioPulseQ[1] <= (tickQ == twelve_bit_pkg::TICK_EV2) && instrRegQ[1];
			ioPulseQ[2] <= (tickQ == twelve_bit_pkg::TICK_EV3) && instrRegQ[2];
		end
		else
			ioPulseQ <= 3'h0;
	end

	// ****************************************
	// wishbone slave
	// ****************************************

	// one wait state: ack in the cycle after the request, then low
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			ackQ <= 1'b0;
		else
			ackQ <= busHit;
	end

	// run control; the engine stops at the next instruction boundary
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			runQ <= 1'b0;
		else if (busWrite && wbReq.adr == twelve_bit_pkg::REG_CTRL && wbReq.sel[0])
			runQ <= wbReq.dat[0];
	end

	// read mux; unmapped offsets answer zero
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			datOutQ <= 32'h00000000;
		else if (busHit)
		begin
			case (wbReq.adr)
				twelve_bit_pkg::REG_CTRL:
					datOutQ <= {31'h00000000, runQ};
				twelve_bit_pkg::REG_PROG_COUNTER:
					datOutQ <= {20'h00000, progCounterQ};
				twelve_bit_pkg::REG_ACC:
					datOutQ <= {19'h00000, linkQ, accQ};
				twelve_bit_pkg::REG_STATUS:
					datOutQ <= {16'h0000, runQ, pauseQ, 2'(stateQ), instrRegQ};
				default:
					datOutQ <= 32'h00000000;
			endcase
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign wbAck = ackQ;
	assign wbDatOut = datOutQ;
	assign memReq = memReqQ;
	assign ioPulse = ioPulseQ;
	// device code for the selectors outside, which do the matching
	assign ioDevice = instrRegQ[8:3];
	assign pauseFlag = pauseQ;

endmodule
`default_nettype wire

// >>> logic/twelve_bit_pkg.sv
// shared constants, types and timing for the twelve-bit decode and execute slice
`default_nettype none
package twelve_bit_pkg;

	// ****************************************
	// timing, all derived from the 100 ns clock
	// ****************************************
	localparam int CLK_NS = 100; // sys_clk period
	localparam int MEM_CYCLE_NS = 1600; // one memory cycle
	localparam int IOT_FETCH_NS = 4250; // stretched fetch of an i/o transfer
	localparam int EVENT_NS = 1000; // spacing of i/o event times
	localparam int MEM_CYC = MEM_CYCLE_NS / CLK_NS; // exact, 16
	localparam int IOT_CYC = (IOT_FETCH_NS + CLK_NS - 1) / CLK_NS; // least time, rounds up
	localparam int EVENT_CYC = EVENT_NS / CLK_NS; // 10
	localparam int TS_LEN = MEM_CYC / 4; // one time state

	// tick positions inside a cycle
	localparam logic [5:0] TICK_LOAD = 6'(2 * TS_LEN - 1); // end of time state 2
	localparam logic [5:0] TICK_SEQ1 = 6'(2 * TS_LEN); // sequence step 1
	localparam logic [5:0] TICK_SEQ2 = 6'(2 * TS_LEN + 1);
	localparam logic [5:0] TICK_SEQ3 = 6'(2 * TS_LEN + 2);
	localparam logic [5:0] TICK_SEQ4 = 6'(2 * TS_LEN + 3);
	localparam logic [5:0] TICK_WRITE = 6'(3 * TS_LEN); // write-back start
	localparam logic [5:0] TICK_MEM_END = 6'(MEM_CYC - 1);
	localparam logic [5:0] TICK_IOT_END = 6'(IOT_CYC - 1);
	localparam logic [5:0] TICK_EV1 = 6'(2 * TS_LEN + EVENT_CYC);
	localparam logic [5:0] TICK_EV2 = 6'(2 * TS_LEN + 2 * EVENT_CYC);
	localparam logic [5:0] TICK_EV3 = 6'(2 * TS_LEN + 3 * EVENT_CYC);

	// ****************************************
	// opcodes (instruction bits 11:9)
	// ****************************************
	localparam logic [2:0] OP_INCR_SKIP_ZERO = 3'h2;
	localparam logic [2:0] OP_DEPOSIT_CLEAR_ACC = 3'h3;
	localparam logic [2:0] OP_JUMP_SUBROUTINE = 3'h4;
	localparam logic [2:0] OP_JUMP_DIRECT = 3'h5;
	localparam logic [2:0] OP_IO_TRANSFER = 3'h6;
	localparam logic [2:0] OP_OPERATE = 3'h7;

	// instruction field positions, lsb numbering
	localparam int B_INDIRECT = 8;
	localparam int B_CUR_PAGE = 7;
	localparam int B_GROUP = 8;
	localparam int B_ZERO_ACC = 7;
	localparam int B_ZERO_LINK = 6;
	localparam int B_INVERT_ACC = 5;
	localparam int B_INVERT_LINK = 4;
	localparam int B_ROT_RIGHT = 3;
	localparam int B_ROT_LEFT = 2;
	localparam int B_ROT_TWO = 1;
	localparam int B_INCR_ACC = 0;
	localparam int B_TEST_MINUS = 6;
	localparam int B_TEST_ACC_ZERO = 5;
	localparam int B_TEST_LINK_SET = 4;
	localparam int B_REVERSE = 3;

	// ****************************************
	// register map and reset values
	// ****************************************
	localparam logic [3:0] REG_CTRL = 4'h0; // bit 0 run
	localparam logic [3:0] REG_PROG_COUNTER = 4'h4;
	localparam logic [3:0] REG_ACC = 4'h8; // bit 12 link
	localparam logic [3:0] REG_STATUS = 4'hc;
	localparam logic [11:0] RST_PROG_COUNTER = 12'h000;
	localparam logic [11:0] RST_ACC = 12'h000;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_DEFER, ST_EXEC} majorState_t;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} wbReq_t;

	typedef struct packed {
		logic [11:0] addr;
		logic [11:0] wrData;
		logic rd;
		logic wr;
	} memReq_t;

endpackage
`default_nettype wire

// >>> test/twelve_bit_checker_sva.sv
// checker: port-level timing and bus properties of the decode slice
`default_nettype none
module twelve_bit_checker (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire twelve_bit_pkg::wbReq_t wbReq,
	input wire logic wbAck,
	input wire logic [31:0] wbDatOut,
	input wire twelve_bit_pkg::memReq_t memReq,
	input wire logic [11:0] memRdData,
	input wire logic [2:0] ioPulse,
	input wire logic [5:0] ioDevice,
	input wire logic pauseFlag
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	// ********
	// helper: clocks spent with pause up
	// ********
	logic [5:0] pauseCnt_q; // cleared whenever pause is low
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			pauseCnt_q <= 6'h00;
		else
			pauseCnt_q <= pauseFlag ? pauseCnt_q + 6'h01 : 6'h00;
	end
	// ********
	// properties
	// ********
	property p_ack_next;
		wbReq.cyc && wbReq.stb && !wbAck |=> wbAck;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("bus request not acked");
	property p_ack_once;
		wbAck |=> !wbAck;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
	property p_unmapped;
		wbAck && !wbReq.we && !(wbReq.adr inside {4'h0, 4'h4, 4'h8, 4'hc}) |-> wbDatOut == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_dat_hold;
		!(wbReq.cyc && wbReq.stb && !wbAck) |=> $stable(wbDatOut);
	endproperty
	a_dat_hold: assert property (p_dat_hold) else $error("read data moved without request");
	property p_rd_gap;
		memReq.rd |=> !memReq.rd [*8] ##1 !memReq.rd [*7];
	endproperty
	a_rd_gap: assert property (p_rd_gap) else $error("memory cycle shorter than 16");
	property p_no_mem_io;
		pauseFlag |-> !memReq.rd && !memReq.wr;
	endproperty
	a_no_mem_io: assert property (p_no_mem_io) else $error("memory access in transfer");
	property p_pause_len;
		$fell(pauseFlag) |-> pauseCnt_q == 6'h22;
	endproperty
	a_pause_len: assert property (p_pause_len) else $error("pause length wrong");
	property p_pulse_slot;
		ioPulse != 3'h0 |-> pauseFlag && (ioPulse == 3'h1 && pauseCnt_q == 6'h0a
			|| ioPulse == 3'h2 && pauseCnt_q == 6'h14 || ioPulse == 3'h4 && pauseCnt_q == 6'h1e);
	endproperty
	a_pulse_slot: assert property (p_pulse_slot) else $error("pulse out of slot");
	property p_wr_slot;
		memReq.wr |-> $past(memReq.rd, 12) && !pauseFlag;
	endproperty
	a_wr_slot: assert property (p_wr_slot) else $error("write-back out of slot");
	// main scenarios reached
	c_write: cover property (memReq.wr);
	c_pulse4: cover property (ioPulse[2]);
	c_unmapped: cover property (wbAck && wbReq.adr == 4'h2);
endmodule
bind twelve_bit_instr_decode_exec twelve_bit_checker u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
	.wbReq(wbReq), .wbAck(wbAck), .wbDatOut(wbDatOut), .memReq(memReq),
	.memRdData(memRdData), .ioPulse(ioPulse), .ioDevice(ioDevice), .pauseFlag(pauseFlag));
`default_nettype wire

// >>> test/core_mem_model.sv
// far side: core word store and one peripheral device selector
`default_nettype none
module core_mem_model #(
	parameter logic [5:0] SEL_CODE = 6'h2a // code this selector answers to
) (
	input wire logic sys_clk,
	input wire twelve_bit_pkg::memReq_t memReq,
	output logic [11:0] memRdData,
	input wire logic [2:0] ioPulse,
	input wire logic [5:0] ioDevice,
	input wire logic clrCnt,
	input wire logic [11:0] stopAddr,
	output int stopAt,
	output int pulseTally
);
	// ********
	// storage
	// ********
	timeunit 1ns;
	timeprecision 1ns;
	logic [11:0] mem [4096]; // loaded by the bench
	logic [3:0] age_q = 4'hf; // clocks since the last read strobe
	int rdCnt_q = 0; // read strobes since the last clear
	// a fresh read shows inverted data first, so early sampling fails
	assign memRdData = (age_q < 4'h3) ? ~mem[memReq.addr] : mem[memReq.addr];
	initial
	begin
		stopAt = -1;
		pulseTally = 0;
		foreach (mem[i])
			mem[i] = 12'h000;
	end
	// ********
	// write-back, strobe count, device selector
	// ********
	always @(posedge sys_clk)
	begin
		age_q <= memReq.rd ? 4'h0 : (age_q == 4'hf ? age_q : age_q + 4'h1);
		if (memReq.wr)
			mem[memReq.addr] <= memReq.wrData;
		if (clrCnt)
		begin
			rdCnt_q <= 0;
			stopAt <= -1;
		end
		else if (memReq.rd)
		begin
			rdCnt_q <= rdCnt_q + 1;
			// first fetch of the parking address marks the program's length
			if (memReq.addr == stopAddr && stopAt < 0)
				stopAt <= rdCnt_q;
		end
		// only a matching selector turns timing pulses into transfers
		if (ioDevice == SEL_CODE)
			pulseTally <= pulseTally + ioPulse[0] + 16 * ioPulse[1] + 256 * ioPulse[2];
	end
endmodule
`default_nettype wire

// >>> test/tb_top.sv
// self-checking bench: bus accesses and short programs in core
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {bit chk; logic [31:0] v; string nm;} note_t;
	// ********
	// signals and bookkeeping
	// ********
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	twelve_bit_pkg::wbReq_t wbReq = '0;
	logic wbAck;
	logic [31:0] wbDatOut;
	twelve_bit_pkg::memReq_t memReq;
	logic [11:0] memRdData;
	logic [2:0] ioPulse;
	logic [5:0] ioDevice;
	logic pauseFlag;
	logic clrCnt = 1'b0;
	logic [11:0] stopAddr = 12'h000;
	int stopAt;
	int pulseTally;
	int errors = 0;
	int checked = 0;
	int cycles = 0;
	int expTally = 0;
	int seed = int'(32'ha251a84d);
	logic [31:0] rdVal; // data of the last bus read
	note_t rdQ [$]; // expected read data, oldest first
	logic [23:0] wrQ [$]; // expected {address, word} write-backs
	// skip increment, indirect increment, deposit, call, indirect jump, park
	logic [11:0] ldA [11] = '{12'h080, 12'h081, 12'h082, 12'h083, 12'h084, 12'h0a1,
		12'h0b0, 12'h010, 12'h0ff, 12'h300, 12'h012};
	logic [11:0] ldD [11] = '{12'h410, 12'he80, 12'h5ff, 12'h611, 12'h8a0, 12'hb12,
		12'hab0, 12'hfff, 12'h300, 12'h005, 12'h0b0};
	// operate, skip and transfer words, one per run
	logic [11:0] ops [25] = '{12'he00, 12'he40, 12'he80, 12'he20, 12'he10, 12'he01,
		12'he21, 12'he04, 12'he08, 12'he06, 12'he0a, 12'he50, 12'hea0, 12'hf20,
		12'hf28, 12'hf10, 12'hf18, 12'hf40, 12'hf48, 12'hf08, 12'hf70, 12'hf78,
		12'hd57, 12'hd55, 12'hc0f};

	always #50 sys_clk = ~sys_clk;

	twelve_bit_instr_decode_exec u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .wbReq(wbReq),
		.wbAck(wbAck), .wbDatOut(wbDatOut), .memReq(memReq), .memRdData(memRdData),
		.ioPulse(ioPulse), .ioDevice(ioDevice), .pauseFlag(pauseFlag));
	core_mem_model u_mem (.sys_clk(sys_clk), .memReq(memReq), .memRdData(memRdData),
		.ioPulse(ioPulse), .ioDevice(ioDevice), .clrCnt(clrCnt), .stopAddr(stopAddr),
		.stopAt(stopAt), .pulseTally(pulseTally));

	// ********
	// comparison and closing
	// ********
	task automatic check_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic check_count(input string nm, input int exp, input int got);
		checked++;
		if (got != exp)
		begin
			errors++;
			$display("[ERR] %s expected %0d seen %0d", nm, exp, got);
		end
	endtask
	task automatic report_and_stop();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ********
	// bus master: hold the request until ack is sampled
	// ********
	task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat,
		input bit chk, input logic [31:0] exp, input string nm);
		if (!we)
			rdQ.push_back('{chk, exp, nm});
		wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h3, dat: dat};
		do
			@(posedge sys_clk);
		while (wbAck !== 1'b1);
		rdVal = wbDatOut;
		wbReq <= '0;
		@(posedge sys_clk);
	endtask
	task automatic wr(input logic [3:0] adr, input logic [31:0] dat);
		wb(1'b1, adr, dat, 1'b0, 32'h0, "");
	endtask
	task automatic rd(input logic [3:0] adr, input logic [31:0] exp, input string nm);
		wb(1'b0, adr, 32'h0, 1'b1, exp, nm);
	endtask

	// expected {skip, link, acc} after one operate word
	function automatic logic [13:0] model(input logic [11:0] ir, input logic [12:0] v);
		logic sk;
		sk = 1'b0;
		if (ir[11:8] == 4'he)
		begin
			if (ir[7]) v[11:0] = 12'h000;
			if (ir[6]) v[12] = 1'b0;
			if (ir[5]) v[11:0] = ~v[11:0];
			if (ir[4]) v[12] = ~v[12];
			if (ir[0]) v[11:0] = v[11:0] + 12'h001;
			repeat (ir[1] ? 2 : 1)
				if (ir[2] && !ir[3]) v = {v[11:0], v[12]};
				else if (ir[3] && !ir[2]) v = {v[0], v[12:1]};
		end
		else if (ir[11:8] == 4'hf)
			sk = ir[3] ^ ((ir[6] & v[11]) | (ir[5] & (v[11:0] == 12'h000)) | (ir[4] & v[12]));
		return {sk, v};
	endfunction

	// load state, run until the parking word is fetched, halt, read back
	task automatic run_prog(input logic [12:0] acc, input logic [11:0] stop, input int cyc,
		input logic [12:0] expAcc, input string nm);
		wr(4'h8, {19'h0, acc});
		wr(4'h4, 32'h80);
		stopAddr <= stop;
		clrCnt <= 1'b1;
		@(posedge sys_clk);
		clrCnt <= 1'b0;
		wr(4'h0, 32'h1);
		while (stopAt < 0)
			@(posedge sys_clk);
		// refused while running: must not reach the accumulator
		wr(4'h8, 32'h0aaa);
		wr(4'h0, 32'h0);
		do
			wb(1'b0, 4'hc, 32'h0, 1'b0, 32'h0, "");
		while (rdVal[13:12] !== 2'h0);
		check_count({nm, " cycles"}, cyc, stopAt);
		rd(4'h8, {19'h0, expAcc}, {nm, " acc"});
		rd(4'h4, {20'h0, stop}, {nm, " pc"});
	endtask

	// ********
	// result watcher: oldest note against each result
	// ********
	always @(posedge sys_clk)
	begin
		note_t n;
		if (wbAck === 1'b1 && wbReq.we === 1'b0)
		begin
			if (rdQ.size() == 0)
				rdQ.push_back('{1'b1, 32'hx, "unexpected read"});
			n = rdQ.pop_front();
			if (n.chk)
				check_word(n.nm, n.v, wbDatOut);
		end
		if (memReq.wr === 1'b1)
		begin
			if (wrQ.size() == 0)
				wrQ.push_back(24'hxxxxxx);
			check_word("write-back", {8'h0, wrQ.pop_front()}, {8'h0, memReq.addr, memReq.wrData});
		end
	end

	// hang guard
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			errors++;
			report_and_stop();
		end
	end

	// ********
	// main sequence
	// ********
	initial
	begin
		logic [11:0] ir;
		logic [12:0] v;
		logic [13:0] e;
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		rd(4'h8, 32'h0, "acc at reset");
		rd(4'h4, 32'h0, "pc at reset");
		rd(4'hc, 32'h0, "status at reset");
		rd(4'h0, 32'h0, "ctrl at reset");
		wr(4'h2, 32'h1fff);
		rd(4'h2, 32'h0, "unmapped");
		foreach (ldA[i])
			u_mem.mem[ldA[i]] = ldD[i];
		wrQ = '{24'h010000, 24'h300006, 24'h011123, 24'h0a0085};
		run_prog(13'h1123, 12'h0b0, 11, 13'h1000, "memref");
		check_count("writes pending", 0, wrQ.size());
		u_mem.mem[12'h081] = 12'ha81;
		u_mem.mem[12'h082] = 12'ha82;
		foreach (ops[i])
			for (int j = 0; j < 2; j++)
			begin
				ir = ops[i];
				v = j ? {13{i[0]}} : 13'($random(seed));
				e = model(ir, v);
				u_mem.mem[12'h080] = ir;
				if (ir[11:9] == 3'h6 && ir[8:3] == 6'h2a)
					expTally += ir[0] + 16 * ir[1] + 256 * ir[2];
				run_prog(v, e[13] ? 12'h082 : 12'h081, 1, e[12:0], "op");
			end
		check_count("io pulses", expTally, pulseTally);
		report_and_stop();
	end
endmodule
`default_nettype wire
